// ### ptm_pkg.sv
// package for the 10-bit periodic timer: register indices, field positions, reset values
// assumes a byte-wide register port with one-cycle read latency
package ptm_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_CMPP_LO = 3'h6;
  localparam logic [2:0] ADDR_CMPP_HI = 3'h7;
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] VALUE_RESET = 10'h000;
  // control zero field positions
  localparam int C0_PAUSE = 7;
  localparam int C0_CLK_HI = 6;
  localparam int C0_CLK_LO = 4;
  localparam int C0_ON = 3;
  // control one field positions
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_FUNC_HI = 5;
  localparam int C1_FUNC_LO = 4;
  localparam int C1_INIT = 3;
  localparam int C1_POL = 2;
  localparam int C1_CAPSRC = 1;
  localparam int C1_CLRSEL = 0;
  // prescale divide ratios
  localparam logic [7:0] DIV_SYS4 = 8'h03;
  localparam logic [7:0] DIV_H16 = 8'h0f;
  localparam logic [7:0] DIV_H64 = 8'h3f;

  typedef enum logic [1:0] {MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER} mode_e;
  typedef enum logic [2:0] {
    CLK_SYS4, CLK_SYS, CLK_H16, CLK_H64, CLK_TBC0, CLK_TBC1, CLK_EXT_RISE, CLK_EXT_FALL
  } clk_sel_e;

  typedef struct packed {
    logic pause;
    clk_sel_e clkSel;
    logic on;
  } ctrl0_s;

  typedef struct packed {
    mode_e mode;
    logic [1:0] func;
    logic initLevel;
    logic polInvert;
    logic capSrc;
    logic clrSel;
  } ctrl1_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// ### periodic_timer.sv
// 10-bit periodic timer: registers, counter, comparators, output and capture logic
// assumes synchronous pins and byte register port, read data one cycle after the strobe
//
// How it works
// - pause bit holds counter; clearing resumes from the held value
// - three-bit field picks counter clock: prescaled, time-base or pin edge
// - on-bit rising edge zeroes the counter and starts; clearing stops it
// - after on-bit falls the counter keeps its residual value
// - compare mode: on-bit rising edge returns pin to initial level
// - unimplemented bits read as zero
// - two-bit mode field: compare, capture, pwm/single pulse, timer
// - compare mode: A match leaves, lowers, raises or toggles pin
// - pwm mode: force inactive, force active, pwm, single pulse
// - capture mode: rising, falling, both edges, or disabled
// - requested level equal to current level shows no pin change
// - initial-level bit sets initial or active level; none in timer mode
// - polarity bit inverts the pin; no effect in timer mode
// - capture source: timer pin when 0, external clock pin when 1
// - clear-select 1 clears on A match; 0 on P match or overflow
// - overflow clear only when compare-P value is all zero
// - clear-select ignored in pwm, single pulse and capture modes
// - counter readable through low and high registers, not writable
// - compare-A and compare-P each held in low byte plus two bits
// - counter clears on overflow or selected match; raises match flags
// - pwm duty at or above period gives constant active output
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module periodic_timer
  import ptm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic tbcTick,
  input wire logic highSpeedTick,
  input wire logic timerIoPinIn,
  input wire logic externalClockPin,
  output logic timerIoPinOut,
  output logic timerIoPinOe,
  output logic matchAFlag,
  output logic matchPFlag
);
  reg_req_s req;
  ctrl0_s ctrl0;
  ctrl1_s ctrl1;
  logic [9:0] counter;
  logic [9:0] compareA;
  logic [9:0] compareP;
  logic [7:0] sysDiv;
  logic [7:0] highDiv;
  logic onPrev;
  logic extPrev;
  logic ioPrev;
  logic level;
  logic pulseDone;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // clock selection
  // clock source mux
  wire extRise = externalClockPin & ~extPrev;
  wire extFall = ~externalClockPin & extPrev;
  wire sysTick4 = (sysDiv[1:0] == DIV_SYS4[1:0]);
  wire highTick16 = highSpeedTick & (highDiv[3:0] == DIV_H16[3:0]);
  wire highTick64 = highSpeedTick & (highDiv[5:0] == DIV_H64[5:0]);
  logic clkTick;
  always_comb begin
    case (ctrl0.clkSel)
      CLK_SYS4: clkTick = sysTick4;
      CLK_SYS: clkTick = 1'b1;
      CLK_H16: clkTick = highTick16;
      CLK_H64: clkTick = highTick64;
      CLK_TBC0, CLK_TBC1: clkTick = tbcTick;
      CLK_EXT_RISE: clkTick = extRise;
      default: clkTick = extFall;
    endcase
  end

  wire isCompare = (ctrl1.mode == MODE_COMPARE);
  wire isCapture = (ctrl1.mode == MODE_CAPTURE);
  wire isPwm = (ctrl1.mode == MODE_PWM);
  wire isTimer = (ctrl1.mode == MODE_TIMER);
  wire isSingle = isPwm & (ctrl1.func == 2'b11);

  wire onRise = ctrl0.on & ~onPrev;
  wire counting = ctrl0.on & ~ctrl0.pause & clkTick & ~onRise;
  wire matchA = counting & (counter == compareA);
  wire matchP = counting & (counter == compareP);
  wire overflow = counting & (counter == CNT_MAX);

  // clear selection, overflow only with zero P, mode gating
  wire pIsZero = (compareP == VALUE_RESET);
  wire clrByA = (isCompare | isTimer) & ctrl1.clrSel;
  wire clrAtP = ~clrByA & ~isSingle & ~pIsZero & matchP;
  wire clrAtOvf = ~clrByA & ~isSingle & pIsZero & overflow;
  wire clearCnt = (clrByA & matchA) | clrAtP | clrAtOvf;

  logic [9:0] next_counter;
  always_comb begin
    if (onRise) begin
      next_counter = VALUE_RESET;
    end else if (clearCnt) begin
      next_counter = VALUE_RESET;
    end else if (counting) begin
      next_counter = counter + 10'h001;
    end else begin
      next_counter = counter;
    end
  end

  // capture event
  // capture source
  wire capIn = ctrl1.capSrc ? externalClockPin : timerIoPinIn;
  wire capPrev = ctrl1.capSrc ? extPrev : ioPrev;
  wire capRise = capIn & ~capPrev;
  wire capFall = ~capIn & capPrev;
  logic capHit;
  always_comb begin
    case (ctrl1.func)
      2'b00: capHit = capRise;
      2'b01: capHit = capFall;
      2'b10: capHit = capRise | capFall;
      default: capHit = 1'b0;
    endcase
  end
  wire doCapture = isCapture & ctrl0.on & capHit;

  // register writes
  wire wrC0 = req.wr & (req.addr == ADDR_CTRL0);
  wire wrC1 = req.wr & (req.addr == ADDR_CTRL1);
  wire wrAL = req.wr & (req.addr == ADDR_CMPA_LO);
  wire wrAH = req.wr & (req.addr == ADDR_CMPA_HI);
  wire wrPL = req.wr & (req.addr == ADDR_CMPP_LO);
  wire wrPH = req.wr & (req.addr == ADDR_CMPP_HI);

  // single pulse: A match clears the on bit
  wire pulseEnd = isSingle & ctrl0.on & matchA;

  ctrl0_s next_ctrl0;
  always_comb begin
    next_ctrl0 = ctrl0;
    if (wrC0) begin
      next_ctrl0 = ctrl0_s'(req.wdata[7:3]);
    end
    if (pulseEnd) begin
      next_ctrl0.on = 1'b0;
    end
  end

  logic [9:0] next_compareA;
  always_comb begin
    next_compareA = compareA;
    if (wrAL) begin
      next_compareA[7:0] = req.wdata;
    end
    if (wrAH) begin
      next_compareA[9:8] = req.wdata[1:0];
    end
    // capture latches the live count into compare-A
    if (doCapture) begin
      next_compareA = counter;
    end
  end

  // output level machine
  logic next_level;
  always_comb begin
    next_level = level;
    if (isCompare) begin
      if (onRise) begin
        next_level = ctrl1.initLevel;
      end else if (matchA) begin
        // compare action, same level is no change
        case (ctrl1.func)
          2'b01: next_level = 1'b0;
          2'b10: next_level = 1'b1;
          2'b11: next_level = ~level;
          default: next_level = level;
        endcase
      end
    end else if (isPwm) begin
      // pwm function select, duty at or above period
      case (ctrl1.func)
        2'b00: next_level = ~ctrl1.initLevel;
        2'b01: next_level = ctrl1.initLevel;
        2'b10: next_level = ((next_counter < compareA) |
                             (~pIsZero & (compareA >= compareP))) ?
                            ctrl1.initLevel : ~ctrl1.initLevel;
        default: next_level = (next_ctrl0.on & ~pulseDone) ?
                              ctrl1.initLevel : ~ctrl1.initLevel;
      endcase
    end
  end

  // initial level and polarity only outside timer and capture modes
  wire pinDrive = ~isTimer & ~isCapture;
  wire next_pinOut = pinDrive & (level ^ ctrl1.polInvert);

  // register read, zero fill, live counter value
  logic [7:0] rdMux;
  always_comb begin
    if (req.addr == ADDR_CTRL0) begin
      rdMux = {ctrl0, 3'b000};
    end else if (req.addr == ADDR_CTRL1) begin
      rdMux = ctrl1;
    end else if (req.addr == ADDR_CNT_LO) begin
      rdMux = counter[7:0];
    end else if (req.addr == ADDR_CNT_HI) begin
      rdMux = {6'h00, counter[9:8]};
    end else if (req.addr == ADDR_CMPA_LO) begin
      rdMux = compareA[7:0];
    end else if (req.addr == ADDR_CMPA_HI) begin
      rdMux = {6'h00, compareA[9:8]};
    end else if (req.addr == ADDR_CMPP_LO) begin
      rdMux = compareP[7:0];
    end else begin
      rdMux = {6'h00, compareP[9:8]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= ctrl0_s'(5'h00);
      ctrl1 <= ctrl1_s'(CTRL_RESET);
      compareA <= VALUE_RESET;
      compareP <= VALUE_RESET;
      counter <= VALUE_RESET;
    end else begin
      ctrl0 <= next_ctrl0;
      if (wrC1) begin
        ctrl1 <= ctrl1_s'(req.wdata);
      end
      compareA <= next_compareA;
      if (wrPL) begin
        compareP[7:0] <= req.wdata;
      end
      if (wrPH) begin
        compareP[9:8] <= req.wdata[1:0];
      end
      counter <= next_counter;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sysDiv <= 8'h00;
      highDiv <= 8'h00;
      onPrev <= 1'b0;
      extPrev <= 1'b0;
      ioPrev <= 1'b0;
    end else begin
      sysDiv <= sysDiv + 8'h01;
      if (highSpeedTick) begin
        highDiv <= highDiv + 8'h01;
      end
      onPrev <= ctrl0.on;
      extPrev <= externalClockPin;
      ioPrev <= timerIoPinIn;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      pulseDone <= 1'b0;
      timerIoPinOut <= 1'b0;
      timerIoPinOe <= 1'b0;
      matchAFlag <= 1'b0;
      matchPFlag <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      level <= next_level;
      pulseDone <= onRise ? 1'b0 : (pulseDone | pulseEnd);
      timerIoPinOut <= next_pinOut;
      // pin released in timer and capture modes
      timerIoPinOe <= pinDrive;
      matchAFlag <= matchA | doCapture;
      matchPFlag <= (matchP & ~clrByA) | clrAtOvf;
      regRdata <= req.rd ? rdMux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### periodic_timer_monitor.sv
// assertions on the periodic timer ports
// bound to every periodic_timer instance; shadows only what software wrote
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_monitor
  import ptm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic timerIoPinOut,
  input wire logic timerIoPinOe,
  input wire logic matchPFlag
);
  ctrl1_s c1;
  logic on, everOn;
  wire logic noP = c1.clrSel && c1.mode inside {MODE_COMPARE, MODE_TIMER};
  wire logic wr0 = regWr && regAddr == ADDR_CTRL0;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c1 <= ctrl1_s'(CTRL_RESET);
      on <= 1'b0;
      everOn <= 1'b0;
    end else begin
      if (regWr && regAddr == ADDR_CTRL1) c1 <= ctrl1_s'(regWdata);
      if (wr0) on <= regWdata[C0_ON];
      everOn <= everOn || (wr0 && regWdata[C0_ON]);
    end
  end
  // software start in compare mode
  sequence onRise;
    wr0 && regWdata[C0_ON] && !on && c1.mode == MODE_COMPARE;
  endsequence
  a_idle_read_zero: assert property (
    !regRd |=> regRdata == 8'h00) else $error("read data not idle");
  a_ctrl0_pad_zero: assert property (
    regRd && regAddr == ADDR_CTRL0 |=> regRdata[2:0] == 3'h0) else $error("pad bits set");
  a_high_pad_zero: assert property (
    regRd && regAddr[0] && regAddr != ADDR_CTRL1 |=> regRdata[7:2] == 6'h00) else $error("high pad");
  a_ctrl1_readback: assert property (
    regRd && regAddr == ADDR_CTRL1 |=> regRdata == c1) else $error("ctrl1 readback");
  a_count_frozen: assert property (
    regRd && regAddr == ADDR_CNT_LO && !everOn |=> regRdata == 8'h00) else $error("count moved");
  a_pin_released: assert property (
    c1.mode inside {MODE_TIMER, MODE_CAPTURE} |=> !timerIoPinOe) else $error("pin driven");
  a_no_p_flag: assert property (
    noP && $past(noP) && $past(noP, 2) |-> !matchPFlag) else $error("p flag raised");
  a_restart_level: assert property (
    onRise |-> ##3 timerIoPinOut == (c1.initLevel ^ c1.polInvert)) else $error("start level");
endmodule
bind periodic_timer periodic_timer_monitor mon (.clock(clock), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .timerIoPinOut(timerIoPinOut), .timerIoPinOe(timerIoPinOe),
  .matchPFlag(matchPFlag));
`default_nettype wire

// ### tb.sv
// self-checking bench for periodic_timer
// the port monitor is attached by its own bind
`timescale 1ns/10ps
`default_nettype none
module tb
  import ptm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0, regRd = 1'b0, tbcTick = 1'b0, highSpeedTick = 1'b0;
  logic timerIoPinIn = 1'b0, externalClockPin = 1'b0;
  logic timerIoPinOut, timerIoPinOe, e, mA;
  int aCount = 0, n;
  logic [7:0] regRdata, v, w;
  int errCount = 0, cmpCount = 0;
  logic [2:0] ra[8] = '{ADDR_CNT_LO, ADDR_CNT_HI, ADDR_CTRL0, ADDR_CTRL1, ADDR_CMPA_LO,
    ADDR_CMPA_HI, ADDR_CMPP_LO, ADDR_CMPP_HI};
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'hf8, 8'hff, 8'hff, 8'h03, 8'hff, 8'h03};
  periodic_timer dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tbcTick(tbcTick),
    .highSpeedTick(highSpeedTick), .timerIoPinIn(timerIoPinIn),
    .externalClockPin(externalClockPin), .timerIoPinOut(timerIoPinOut),
    .timerIoPinOe(timerIoPinOe), .matchAFlag(mA), .matchPFlag());
  initial forever #2.5 clock = ~clock;
  // counts compare-A flag pulses so scenarios can see one was raised
  always @(posedge clock) begin
    if (mA === 1'b1) aCount <= aCount + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // an idle cycle follows each strobe so no signal is driven twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    cyc(1);
    regWr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    #1 d = regRdata;
    cyc(1);
  endtask
  task automatic chk(input string s, input logic [9:0] x, input logic [9:0] y);
    cmpCount++;
    if (y !== x) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] x);
    rd(a, v);
    chk($sformatf("register %0d", a), 10'(x), 10'(v));
  endtask
  task automatic pulses(input int n, input logic useExt);
    for (int i = 0; i < n; i++) begin
      externalClockPin <= useExt;
      tbcTick <= 1'b1;
      highSpeedTick <= 1'b1;
      cyc(1);
      tbcTick <= 1'b0;
      highSpeedTick <= 1'b0;
      externalClockPin <= useExt && i == n - 1;
      cyc(1);
    end
  endtask
  task automatic start(input logic [7:0] c1, input logic [7:0] c0);
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CTRL0, c0);
    cyc(2);
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(1);
    for (int a = 0; a < 8; a++) rdChk(3'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ra[i], 8'hff);
      rdChk(ra[i], rv[i]);
    end
    for (int a = 0; a < 8; a++) wr(3'(a), 8'h00);
    start(8'hc0, 8'h18);
    cyc(20);
    wr(ADDR_CTRL0, 8'h98);
    rd(ADDR_CNT_LO, w);
    cyc(10);
    rdChk(ADDR_CNT_LO, w);
    wr(ADDR_CTRL0, 8'h18);
    cyc(4);
    wr(ADDR_CTRL0, 8'h10);
    rd(ADDR_CNT_LO, v);
    chk("resumed", 10'h1, 10'(v > w));
    cyc(10);
    rdChk(ADDR_CNT_LO, v);
    for (int i = 0; i < 6; i++) begin
      externalClockPin <= 1'b0;
      start(8'hc0, {1'b0, 3'(i + 2), 4'h8});
      pulses(i == 0 ? 32 : i == 1 ? 128 : 5, 1'b1);
      cyc(6);
      rdChk(ADDR_CNT_LO, i < 2 ? 8'h02 : i == 5 ? 8'h04 : 8'h05);
    end
    wr(ADDR_CMPA_LO, 8'h02);
    for (int k = 0; k < 16; k++) begin
      externalClockPin <= 1'b0;
      start({2'b00, 2'(k), k[2], k[3], 1'b0, k[3]}, 8'h68);
      chk("initial pin", 10'(k[2] ^ k[3]), 10'(timerIoPinOut));
      n = aCount;
      pulses(3, 1'b1);
      cyc(6);
      chk("a flag", 10'h1, 10'(aCount > n));
      e = (k % 4 == 0) ? k[2] : (k % 4 == 3) ? !k[2] : k[1];
      chk("match pin", 10'(e ^ k[3]), 10'(timerIoPinOut));
      rdChk(ADDR_CNT_LO, k[3] ? 8'h00 : 8'h03);
    end
    wr(ADDR_CMPP_LO, 8'h01);
    externalClockPin <= 1'b0;
    start(8'hc0, 8'h68);
    pulses(3, 1'b1);
    cyc(6);
    rdChk(ADDR_CNT_LO, 8'h01);
    wr(ADDR_CMPA_LO, 8'h05);
    wr(ADDR_CMPP_LO, 8'h03);
    for (int k = 0; k < 12; k++) begin
      start({2'b10, 2'(k / 4), 2'(k), 2'b00}, 8'h18);
      cyc(8);
      chk("pwm pin", 10'(k[0] ^ k[1] ^ (k < 4)), 10'(timerIoPinOut));
      chk("pwm enable", 10'h1, 10'(timerIoPinOe));
    end
    start(8'hb8, 8'h18);
    cyc(20);
    chk("pulse pin", 10'h0, 10'(timerIoPinOut));
    rdChk(ADDR_CTRL0, 8'h10);
    wr(ADDR_CMPP_LO, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL0, 8'h00);
      timerIoPinIn <= 1'b0;
      externalClockPin <= 1'b0;
      cyc(4);
      wr(ADDR_CMPA_LO, 8'h2a);
      start({2'b01, 2'(k), 2'b00, k[2], 1'b0}, 8'h48);
      pulses(3, 1'b0);
      cyc(4);
      if (k[2])
        externalClockPin <= 1'b1;
      else
        timerIoPinIn <= 1'b1;
      cyc(6);
      rdChk(ADDR_CMPA_LO, k[0] ? 8'h2a : 8'h03);
      chk("capture enable", 10'h0, 10'(timerIoPinOe));
    end
    printVerdict();
  end
endmodule
`default_nettype wire
